// ### iap_flash_data_control_regs.sv
// Purpose: Data word and main control registers for flash programming.
// Assumes: Register strobes are one-cycle and synchronous to clock.
// Notes: Address pair lives outside; this block requests its update.
`include "iap_flash_map.svh"

// What this block does
// - Writing word zero low byte only stores that byte.
// - Writing word zero high byte loads the whole word into the buffer while erase and write are enabled.
// - Each buffer load increments the flash address by one.
// - Increment stops when the word-in-page bits are all ones.
// - Buffer holds 32 words mapped to the page of the upper address bits.
// - Four 16-bit data words, byte-wise read/write, reset to zero.
// - Enabled status set only by hardware; writing one does nothing.
// - Software clearing enabled status disables erase and write.
// - Mode 000 write, 001 page erase, 011 read, 110 unlock.
// - Trigger starts a timer; hardware clears trigger on expiry.
// - Pattern 00,0D,C3 low then 04,09,40 high, else stay disabled.
// - Write initiate starts write or erase; hardware clears when done.
// - Reads only while read enable is one.
// - Read initiate starts a read; hardware clears when done.
// - The CPU is stalled while an operation is in progress.
module iap_flash_data_control_regs #(
   parameter int UNLOCK_CYCLES = `UNLOCK_WINDOW_CYCLES,
   parameter int PAGE_WORDS = `PAGE_WORDS
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] sfr_index,
   input wire logic sfr_write,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire iap_flash_pkg::flash_addr_t flash_addr,
   output logic addr_update,
   output iap_flash_pkg::flash_addr_t addr_update_value,
   output logic cpu_stall,
   output logic erase_write_allowed,
   output logic flash_start,
   output iap_flash_pkg::op_mode_e flash_mode,
   output logic [8:0] flash_page,
   input wire logic flash_done,
   input wire iap_flash_pkg::flash_word_t flash_read_word,
   input wire logic [`WORD_BITS-1:0] buffer_read_index,
   output iap_flash_pkg::flash_word_t buffer_read_word
);
   import iap_flash_pkg::*;

   localparam int CW = $clog2(UNLOCK_CYCLES + 1);

   // ************************************************************
   // Helper functions
   // ************************************************************
   function automatic logic index_hit(input logic [3:0] idx,
                                      input logic [3:0] target);
      index_hit = (idx == target);
   endfunction : index_hit

   function automatic logic erase_write_mode(input logic [2:0] m);
      erase_write_mode = (m == mode_write) || (m == mode_page_erase);
   endfunction : erase_write_mode

   function automatic flash_addr_t next_address(input flash_addr_t a);
      if (a[`WORD_BITS-1:0] == 5'h1f) begin
         next_address = a;
      end else begin
         next_address = flash_addr_t'(a + 14'h0001);
      end
   endfunction : next_address

   // ************************************************************
   // State
   // ************************************************************
   logic [7:0] word_low [4];
   logic [7:0] word_high [4];
   logic [7:0] next_word_low [4];
   logic [7:0] next_word_high [4];
   logic enabled, next_enabled;
   logic [2:0] mode_field, next_mode_field;
   logic trigger, next_trigger;
   logic write_init, next_write_init;
   logic read_en, next_read_en;
   logic read_init, next_read_init;
   logic [CW-1:0] timer, next_timer;
   seq_state_e state, next_state;
   logic next_flash_start;
   logic next_addr_update;
   flash_addr_t next_addr_value;
   logic buf_load, buf_clear;
   logic ctl_write, timer_expire, pattern_ok;
   logic unlock_ok;
   logic start_ew, start_rd;
   logic [7:0] ctl_value;

   assign ctl_write = sfr_write &&
                      index_hit(sfr_index, `SFR_FLASH_CONTROL_MAIN);
   assign timer_expire = trigger && (timer == CW'(1));
   assign pattern_ok = word_low[1] == `UNLOCK_W1_LOW &&
                       word_low[2] == `UNLOCK_W2_LOW &&
                       word_low[3] == `UNLOCK_W3_LOW &&
                       word_high[1] == `UNLOCK_W1_HIGH &&
                       word_high[2] == `UNLOCK_W2_HIGH &&
                       word_high[3] == `UNLOCK_W3_HIGH;
   // A success on the expiry edge outranks a software clear of the status
   assign unlock_ok = timer_expire && pattern_ok &&
                      mode_field == mode_unlock;

   // ************************************************************
   // Data word registers
   // ************************************************************
   always_comb begin
      next_word_low = word_low;
      next_word_high = word_high;
      buf_load = 1'b0;
      next_addr_update = 1'b0;
      next_addr_value = addr_update_value;
      for (int i = 0; i < 4; i++) begin
         if (sfr_write && index_hit(sfr_index, 4'(2 * i))) begin
            next_word_low[i] = sfr_wdata;
         end
         if (sfr_write && index_hit(sfr_index, 4'(2 * i + 1))) begin
            next_word_high[i] = sfr_wdata;
         end
      end
      if (state == seq_read && flash_done) begin
         next_word_low[0] = flash_read_word[7:0];
         next_word_high[0] = flash_read_word[15:8];
      end
      // Tagging and loading need erase and write enabled
      if (sfr_write && index_hit(sfr_index, `SFR_DATA_WORD0_HIGH) &&
          enabled) begin
         buf_load = 1'b1;
         next_addr_update = 1'b1;
         next_addr_value = next_address(flash_addr);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            word_low[i] <= `DATA_RESET;
            word_high[i] <= `DATA_RESET;
         end
         addr_update <= 1'b0;
         addr_update_value <= 14'h0000;
      end else begin
         word_low <= next_word_low;
         word_high <= next_word_high;
         addr_update <= next_addr_update;
         addr_update_value <= next_addr_value;
      end
   end

   // ************************************************************
   // Page write buffer
   // ************************************************************
   assign buf_clear = (state == seq_erase_write) && flash_done;

   write_buffer #(
      .DEPTH(PAGE_WORDS),
      .AW(`WORD_BITS)
   ) u_buffer (
      .clock(clock),
      .rst(rst),
      .clear(buf_clear),
      .load(buf_load),
      .load_index(flash_addr[`WORD_BITS-1:0]),
      .load_word({sfr_wdata, word_low[0]}),
      .read_index(buffer_read_index),
      .read_word(buffer_read_word)
   );

   // ************************************************************
   // Unlock window timer
   // ************************************************************
   always_comb begin
      next_timer = timer;
      if (trigger) begin
         next_timer = CW'(timer - CW'(1));
      end
      // Writing the trigger again restarts the whole window
      if (ctl_write && state == seq_idle &&
          sfr_wdata[`CTL_UNLOCK_TRIGGER]) begin
         next_timer = CW'(UNLOCK_CYCLES);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         timer <= '0;
      end else begin
         timer <= next_timer;
      end
   end

   // ************************************************************
   // Unlock procedure and control register
   // ************************************************************
   always_comb begin
      next_enabled = enabled;
      next_mode_field = mode_field;
      next_trigger = trigger;
      next_write_init = write_init;
      next_read_en = read_en;
      next_read_init = read_init;
      start_ew = 1'b0;
      start_rd = 1'b0;
      if (timer_expire) begin
         next_trigger = 1'b0;
      end
      if (unlock_ok) begin
         next_enabled = 1'b1;
      end
      if (state == seq_erase_write && flash_done) begin
         next_write_init = 1'b0;
      end
      if (state == seq_read && flash_done) begin
         next_read_init = 1'b0;
      end
      // Ignored while busy, so a running operation cannot be re-armed
      if (ctl_write && state == seq_idle) begin
         next_mode_field = sfr_wdata[`CTL_MODE_HI:`CTL_MODE_LO];
         next_read_en = sfr_wdata[`CTL_READ_ENABLE];
         if (!sfr_wdata[`CTL_ERASE_WRITE_ENABLED] && !unlock_ok) begin
            next_enabled = 1'b0;
         end
         if (sfr_wdata[`CTL_UNLOCK_TRIGGER]) begin
            next_trigger = 1'b1;
         end
         if (sfr_wdata[`CTL_WRITE_INITIATE]) begin
            if (enabled && next_enabled &&
                erase_write_mode(next_mode_field)) begin
               next_write_init = 1'b1;
               start_ew = 1'b1;
            end
         end else if (sfr_wdata[`CTL_READ_INITIATE]) begin
            if (next_read_en && next_mode_field == mode_read) begin
               next_read_init = 1'b1;
               start_rd = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         enabled <= 1'b0;
         mode_field <= 3'h0;
         trigger <= 1'b0;
         write_init <= 1'b0;
         read_en <= 1'b0;
         read_init <= 1'b0;
      end else begin
         enabled <= next_enabled;
         mode_field <= next_mode_field;
         trigger <= next_trigger;
         write_init <= next_write_init;
         read_en <= next_read_en;
         read_init <= next_read_init;
      end
   end

   // ************************************************************
   // Operation sequencer
   // ************************************************************
   always_comb begin
      next_state = state;
      next_flash_start = 1'b0;
      case (state)
         seq_idle: begin
            if (start_ew) begin
               next_state = seq_erase_write;
               next_flash_start = 1'b1;
            end else if (start_rd) begin
               next_state = seq_read;
               next_flash_start = 1'b1;
            end
         end
         seq_erase_write: begin
            if (flash_done) begin
               next_state = seq_idle;
            end
         end
         seq_read: begin
            if (flash_done || !read_en) begin
               next_state = seq_idle;
            end
         end
         default: begin
            next_state = seq_idle;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state <= seq_idle;
         flash_start <= 1'b0;
      end else begin
         state <= next_state;
         flash_start <= next_flash_start;
      end
   end

   // ************************************************************
   // Outputs and register read-back
   // ************************************************************
   assign cpu_stall = (state != seq_idle);
   assign erase_write_allowed = enabled;
   assign flash_mode = op_mode_e'(mode_field);
   assign flash_page = flash_addr[13:5];
   always_comb begin
      ctl_value = `CTL_RESET;
      ctl_value[`CTL_ERASE_WRITE_ENABLED] = enabled;
      ctl_value[`CTL_MODE_HI:`CTL_MODE_LO] = mode_field;
      ctl_value[`CTL_UNLOCK_TRIGGER] = trigger;
      ctl_value[`CTL_WRITE_INITIATE] = write_init;
      ctl_value[`CTL_READ_ENABLE] = read_en;
      ctl_value[`CTL_READ_INITIATE] = read_init;
   end

   always_comb begin
      sfr_rdata = 8'h00;
      if (sfr_index == `SFR_FLASH_CONTROL_MAIN) begin
         sfr_rdata = ctl_value;
      end else if (sfr_index == `SFR_DATA_WORD0_LOW) begin
         sfr_rdata = word_low[0];
      end else if (sfr_index == `SFR_DATA_WORD0_HIGH) begin
         sfr_rdata = word_high[0];
      end else if (sfr_index == `SFR_DATA_WORD1_LOW) begin
         sfr_rdata = word_low[1];
      end else if (sfr_index == `SFR_DATA_WORD1_HIGH) begin
         sfr_rdata = word_high[1];
      end else if (sfr_index == `SFR_DATA_WORD2_LOW) begin
         sfr_rdata = word_low[2];
      end else if (sfr_index == `SFR_DATA_WORD2_HIGH) begin
         sfr_rdata = word_high[2];
      end else if (sfr_index == `SFR_DATA_WORD3_LOW) begin
         sfr_rdata = word_low[3];
      end else if (sfr_index == `SFR_DATA_WORD3_HIGH) begin
         sfr_rdata = word_high[3];
      end
   end

endmodule : iap_flash_data_control_regs

// ### iap_flash_map.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Eight-bit special function register access by index.
// Notes: Included by the package and by the design files.
`ifndef IAP_FLASH_MAP_SVH
`define IAP_FLASH_MAP_SVH

// ************************************************************
// Register indices
// ************************************************************
`define SFR_DATA_WORD0_LOW 4'h0
`define SFR_DATA_WORD0_HIGH 4'h1
`define SFR_DATA_WORD1_LOW 4'h2
`define SFR_DATA_WORD1_HIGH 4'h3
`define SFR_DATA_WORD2_LOW 4'h4
`define SFR_DATA_WORD2_HIGH 4'h5
`define SFR_DATA_WORD3_LOW 4'h6
`define SFR_DATA_WORD3_HIGH 4'h7
`define SFR_FLASH_CONTROL_MAIN 4'h8

// ************************************************************
// Control register fields and reset values
// ************************************************************
`define CTL_ERASE_WRITE_ENABLED 7
`define CTL_MODE_HI 6
`define CTL_MODE_LO 4
`define CTL_UNLOCK_TRIGGER 3
`define CTL_WRITE_INITIATE 2
`define CTL_READ_ENABLE 1
`define CTL_READ_INITIATE 0
`define DATA_RESET 8'h00
`define CTL_RESET 8'h00

// ************************************************************
// Unlock pattern, words one to three
// ************************************************************
`define UNLOCK_W1_LOW 8'h00
`define UNLOCK_W2_LOW 8'h0d
`define UNLOCK_W3_LOW 8'hc3
`define UNLOCK_W1_HIGH 8'h04
`define UNLOCK_W2_HIGH 8'h09
`define UNLOCK_W3_HIGH 8'h40

// ************************************************************
// Timing
// ************************************************************
`define CLOCK_PERIOD_NS 4
`define UNLOCK_WINDOW_NS 1000
`define UNLOCK_WINDOW_CYCLES (`UNLOCK_WINDOW_NS / `CLOCK_PERIOD_NS)
`define PAGE_WORDS 32
`define WORD_BITS 5

`endif

// ### iap_flash_pkg.sv
// Purpose: Types shared by the flash register interface.
// Assumes: iap_flash_map.svh holds the numbers.
// Notes: Mode codes follow the control register mode field.
`include "iap_flash_map.svh"

package iap_flash_pkg;

   typedef enum logic [2:0] {
      mode_write = 3'b000,
      mode_page_erase = 3'b001,
      mode_read = 3'b011,
      mode_unlock = 3'b110
   } op_mode_e;

   typedef enum logic [1:0] {
      seq_idle = 2'b00,
      seq_erase_write = 2'b01,
      seq_read = 2'b10
   } seq_state_e;

   typedef logic [13:0] flash_addr_t;
   typedef logic [15:0] flash_word_t;

endpackage : iap_flash_pkg

// ### write_buffer.sv
// Purpose: One page of staged write data.
// Assumes: Synchronous clear, one write and one read port.
// Notes: Cleared as a whole when a write completes.
`include "iap_flash_map.svh"

module write_buffer #(
   parameter int DEPTH = `PAGE_WORDS,
   parameter int AW = `WORD_BITS
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic clear,
   input wire logic load,
   input wire logic [AW-1:0] load_index,
   input wire iap_flash_pkg::flash_word_t load_word,
   input wire logic [AW-1:0] read_index,
   output iap_flash_pkg::flash_word_t read_word
);
   import iap_flash_pkg::*;

   flash_word_t mem [DEPTH];
   flash_word_t next_mem [DEPTH];

   always_comb begin
      next_mem = mem;
      if (clear) begin
         for (int i = 0; i < DEPTH; i++) begin
            next_mem[i] = 16'h0000;
         end
      end else if (load) begin
         next_mem[load_index] = load_word;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= 16'h0000;
         end
      end else begin
         mem <= next_mem;
      end
   end

   assign read_word = mem[read_index];

endmodule : write_buffer

// ### iap_flash_data_control_regs_assertions.sv
// Purpose: Port checks of the flash data and control register block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every instance of the block.
`include "iap_flash_map.svh"

module iap_flash_checker #(
   parameter int UNLOCK_CYCLES = 250,
   parameter int PAGE_WORDS = 32
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] sfr_index,
   input wire logic sfr_write,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire iap_flash_pkg::flash_addr_t flash_addr,
   input wire logic addr_update,
   input wire iap_flash_pkg::flash_addr_t addr_update_value,
   input wire logic cpu_stall,
   input wire logic erase_write_allowed,
   input wire logic flash_start,
   input wire iap_flash_pkg::op_mode_e flash_mode,
   input wire logic [8:0] flash_page,
   input wire logic flash_done,
   input wire iap_flash_pkg::flash_word_t flash_read_word,
   input wire logic [`WORD_BITS-1:0] buffer_read_index,
   input wire iap_flash_pkg::flash_word_t buffer_read_word
);
   import iap_flash_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ****************
   // Checks
   // ****************
   sequence s_ctl_wr;
      sfr_write && sfr_index == `SFR_FLASH_CONTROL_MAIN && !cpu_stall;
   endsequence
   sequence s_load;
      sfr_write && sfr_index == `SFR_DATA_WORD0_HIGH && erase_write_allowed;
   endsequence
   a_no_stray_load: assert property (
      sfr_write && !(sfr_index == `SFR_DATA_WORD0_HIGH && erase_write_allowed)
      |=> !addr_update) else $error("address update without a word load");
   a_load_incr: assert property (
      s_load ##0 flash_addr[4:0] != 5'h1f |=> addr_update &&
      addr_update_value == $past(flash_addr) + 14'h0001)
      else $error("address did not advance after a word load");
   a_load_sat: assert property (
      s_load ##0 flash_addr[4:0] == 5'h1f |=> addr_update &&
      addr_update_value == $past(flash_addr))
      else $error("address moved past the last word of the page");
   a_set_by_unlock: assert property (
      $rose(erase_write_allowed) |-> flash_mode == mode_unlock)
      else $error("enable status set outside the unlock mode");
   a_clear_disables: assert property (
      s_ctl_wr ##0 !sfr_wdata[7] && flash_mode != mode_unlock
      |=> !erase_write_allowed) else $error("enable status not cleared");
   a_write_start: assert property (
      s_ctl_wr ##0 sfr_wdata[2] && sfr_wdata[7] && erase_write_allowed &&
      sfr_wdata[6:5] == 2'b00 |=> flash_start && cpu_stall)
      else $error("write or erase did not start");
   a_write_refused: assert property (
      s_ctl_wr ##0 sfr_wdata[2:0] == 3'b100 && !erase_write_allowed
      |=> !flash_start) else $error("write started while disabled");
   a_read_gated: assert property (
      s_ctl_wr ##0 sfr_wdata[2:0] == 3'b001 |=> !flash_start)
      else $error("read started without read enable");
   a_read_start: assert property (
      s_ctl_wr ##0 sfr_wdata[6:4] == 3'b011 && sfr_wdata[2:0] == 3'b011
      |=> flash_start && flash_mode == mode_read)
      else $error("read did not start");
   a_stall_hold: assert property (
      flash_start |=> cpu_stall && !flash_start)
      else $error("stall missing after start");
   a_done_release: assert property (
      cpu_stall && flash_done |=> !cpu_stall)
      else $error("stall held after completion");
   a_reserved_refused: assert property (
      s_ctl_wr ##0 sfr_wdata[2] && sfr_wdata[6:5] != 2'b00 |=> !flash_start)
      else $error("write started in a mode that is not write or erase");
   a_page_select: assert property (
      flash_page == flash_addr[13:5])
      else $error("page select differs from the upper address bits");
endmodule : iap_flash_checker

bind iap_flash_data_control_regs iap_flash_checker #(
   .UNLOCK_CYCLES(UNLOCK_CYCLES), .PAGE_WORDS(PAGE_WORDS)
) iap_flash_checker_inst (.clock, .rst, .sfr_index, .sfr_write, .sfr_wdata,
   .sfr_rdata, .flash_addr, .addr_update, .addr_update_value, .cpu_stall,
   .erase_write_allowed, .flash_start, .flash_mode, .flash_page,
   .flash_done, .flash_read_word, .buffer_read_index, .buffer_read_word);

// ### flash_macro_model.sv
// Purpose: Flash array and address pair seen from the register block.
// Assumes: Start is a one-cycle pulse.
// Notes: Read data is only valid with done; it toggles otherwise.
module flash_macro_model #(
   parameter logic [15:0] READ_SALT = 16'h5a00
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic slow,
   input wire logic addr_set,
   input wire iap_flash_pkg::flash_addr_t addr_set_value,
   input wire logic addr_update,
   input wire iap_flash_pkg::flash_addr_t addr_update_value,
   input wire logic flash_start,
   output iap_flash_pkg::flash_addr_t flash_addr,
   output logic flash_done,
   output iap_flash_pkg::flash_word_t flash_read_word
);
   import iap_flash_pkg::*;
   int busy;
   // ****************
   // Array timing
   // ****************
   always @(posedge clock) begin
      flash_done <= 1'b0;
      flash_read_word <= ~flash_read_word;
      if (rst) begin
         flash_addr <= 14'h0000;
         busy <= 0;
         flash_read_word <= 16'h0000;
      end else begin
         if (addr_set)
            flash_addr <= addr_set_value;
         else if (addr_update)
            flash_addr <= addr_update_value;
         if (flash_start)
            busy <= slow ? 24 : 3;
         else if (busy == 1) begin
            flash_done <= 1'b1;
            flash_read_word <= READ_SALT ^ {2'b00, flash_addr};
            busy <= 0;
         end else if (busy > 0)
            busy <= busy - 1;
      end
   end
endmodule : flash_macro_model

// ### tb_iap_flash_data_control_regs.sv
// Purpose: Self-checking bench of the flash register block.
// Assumes: Short unlock window parameter.
// Notes: Results are queued by the driver and checked on negedge.
module tb_iap_flash_data_control_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import iap_flash_pkg::*;
   localparam logic [15:0] SALT = 16'h5a00;
   logic clock = 0, rst = 1, sfr_write = 0, slow = 0, addr_set = 0, chk = 0;
   logic [3:0] sfr_index = 4'h0;
   logic [7:0] sfr_wdata = 8'h00, sfr_rdata, d;
   logic [4:0] buffer_read_index = 5'h00;
   logic addr_update, cpu_stall, erase_write_allowed, flash_start, flash_done;
   logic [8:0] flash_page;
   flash_addr_t flash_addr, addr_update_value, addr_set_value = 14'h0000;
   flash_word_t flash_read_word, buffer_read_word;
   op_mode_e flash_mode;
   logic [1:0] sel = 2'h0;
   logic [15:0] exp_q[$];
   logic [15:0] obs, want, w;
   logic [7:0] pat [6] = '{8'h00, 8'h0d, 8'hc3, 8'h04, 8'h09, 8'h40};
   int errors = 0, n_tests = 0, cycles = 0;
   integer seed = 32'hc7c67180;

   iap_flash_data_control_regs #(.UNLOCK_CYCLES(20))
      iap_flash_data_control_regs_inst (.clock, .rst, .sfr_index, .sfr_write,
      .sfr_wdata, .sfr_rdata, .flash_addr, .addr_update, .addr_update_value,
      .cpu_stall, .erase_write_allowed, .flash_start, .flash_mode,
      .flash_page, .flash_done, .flash_read_word, .buffer_read_index,
      .buffer_read_word);
   flash_macro_model #(.READ_SALT(SALT)) flash_macro_model_inst (.clock,
      .rst, .slow, .addr_set, .addr_set_value, .addr_update,
      .addr_update_value, .flash_start, .flash_addr, .flash_done,
      .flash_read_word);

   initial begin
      forever #2 clock = ~clock;
   end
   // ****************
   // Monitor
   // ****************
   always @(negedge clock) begin
      if (chk) begin
         case (sel)
            2'h0: obs = {8'h00, sfr_rdata};
            2'h1: obs = buffer_read_word;
            2'h2: obs = {2'b00, flash_addr};
            default: obs = {15'h0000, cpu_stall};
         endcase
         want = exp_q.pop_front();
         n_tests++;
         if (obs !== want) begin
            errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, want, obs);
         end
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         final_report();
      end
   end
   // ****************
   // Tasks
   // ****************
   task final_report;
      if (errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   task look(input logic [1:0] s, input logic [15:0] v);
      @(posedge clock);
      exp_q.push_back(v);
      sel <= s;
      chk <= 1'b1;
      @(posedge clock);
      chk <= 1'b0;
   endtask : look
   task probe(input logic [1:0] s, input logic [4:0] i, input logic [15:0] v);
      @(posedge clock);
      sfr_index <= i[3:0];
      buffer_read_index <= i;
      look(s, v);
   endtask : probe
   task wr(input logic [3:0] i, input logic [7:0] v);
      @(posedge clock);
      sfr_index <= i;
      sfr_wdata <= v;
      sfr_write <= 1'b1;
      @(posedge clock);
      sfr_write <= 1'b0;
   endtask : wr
   task wait_idle;
      int n;
      n = 0;
      @(posedge clock);
      while (cpu_stall !== 1'b0 && n < 100) begin
         @(posedge clock);
         n++;
      end
      if (n == 100) errors++;
   endtask : wait_idle
   // ****************
   // Sequence
   // ****************
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++) probe(2'h0, 5'(i), 16'h0000);
      for (int i = 0; i < 8; i++) begin
         d = 8'($random(seed));
         wr(4'(i), d);
         probe(2'h0, 5'(i), {8'h00, d});
      end
      look(2'h2, 16'h0000);
      wr(4'h8, 8'h80);
      probe(2'h0, 5'h08, 16'h0000);
      wr(4'h8, 8'h04);
      probe(2'h0, 5'h08, 16'h0000);
      wr(4'h8, 8'h31);
      probe(2'h0, 5'h08, 16'h0030);
      @(posedge clock);
      addr_set <= 1'b1;
      addr_set_value <= 14'h0a5e;
      @(posedge clock);
      addr_set <= 1'b0;
      w = SALT ^ 16'h0a5e;
      wr(4'h8, 8'h33);
      look(2'h3, 16'h0001);
      wait_idle();
      probe(2'h0, 5'h00, {8'h00, w[7:0]});
      probe(2'h0, 5'h01, {8'h00, w[15:8]});
      probe(2'h0, 5'h08, 16'h0032);
      for (int k = 0; k < 2; k++) begin
         wr(4'h8, 8'h68);
         for (int i = 0; i < 6; i++)
            wr(4'(2 + 2 * (i % 3) + i / 3), pat[i] ^ 8'(k == 0 && i == 5));
         probe(2'h0, 5'h08, 16'h0068);
         repeat (12) @(posedge clock);
         probe(2'h0, 5'h08, k ? 16'h00e0 : 16'h0060);
      end
      wr(4'h0, 8'h11);
      wr(4'h1, 8'h22);
      look(2'h2, 16'h0a5f);
      wr(4'h1, 8'h33);
      look(2'h2, 16'h0a5f);
      probe(2'h1, 5'h1e, 16'h2211);
      probe(2'h1, 5'h1f, 16'h3311);
      slow <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         wr(4'h8, k ? 8'h94 : 8'h84);
         look(2'h3, 16'h0001);
         wait_idle();
         probe(2'h0, 5'h08, k ? 16'h0090 : 16'h0080);
         probe(2'h1, 5'h1e, 16'h0000);
      end
      wr(4'h8, 8'ha4);
      probe(2'h0, 5'h08, 16'h00a0);
      wr(4'h8, 8'h00);
      probe(2'h0, 5'h08, 16'h0000);
      wr(4'h1, 8'h55);
      look(2'h2, 16'h0a5f);
      probe(2'h1, 5'h1f, 16'h0000);
      final_report();
   end
endmodule : tb_iap_flash_data_control_regs
